// ### rtl/gts_consts.svh
/*
 Register offsets, field positions, reset values and timing counts
 for the gate output turn-off sequencer.
 Assumes a 125 MHz pclk and an 8-bit APB byte address.
*/
`ifndef GTS_CONSTS_SVH
`define GTS_CONSTS_SVH

`define GTS_CLK_NS 8
`define GTS_PROP_NS 40
`define GTS_PROP_CYC ((`GTS_PROP_NS + `GTS_CLK_NS - 1) / `GTS_CLK_NS)
`define GTS_DSOUT_NS 200
`define GTS_DSOUT_CYC ((`GTS_DSOUT_NS + `GTS_CLK_NS - 1) / `GTS_CLK_NS)

`define GTS_A_CTRL 8'h00
`define GTS_A_DCFG 8'h04
`define GTS_A_FMET 8'h08
`define GTS_A_FDLY 8'h0C
`define GTS_A_TSA 8'h10
`define GTS_A_TSB 8'h14
`define GTS_A_SINK 8'h18
`define GTS_A_FEV 8'h1C
`define GTS_A_STAT 8'h20

`define GTS_RST_FDLY 16'h0000
`define GTS_RST_RA 8'h10
`define GTS_RST_RB 8'h10
`define GTS_RST_PLV 8'h80
`define GTS_RST_PTM 8'h20
`define GTS_RST_SINK 4'h8

`define GTS_I_CMD 0
`define GTS_I_RDY 1
`define GTS_I_FLT 2
`define GTS_I_LOGIC_SIDE_SUPPLY 3
`define GTS_I_GATE_POSITIVE_RAIL 4
`define GTS_I_DS 5
`define GTS_I_GF 6
`define GTS_I_GH 7

`endif

// ### rtl/gts_pkg.sv
/*
 Types shared by the gate output turn-off sequencer.
 Assumes nothing of its surroundings.
*/
package gts_pkg;
    typedef enum logic [1:0] {OFF_HARD, OFF_TWO, OFF_SOFT} gts_off_mode_t;
    typedef enum logic [2:0] {
        PH_IDLE, PH_HARD, PH_RAMPA, PH_PLAT, PH_RAMPB, PH_SOFT
    } gts_phase_t;
    typedef enum logic [3:0] {
        ST_CFG, ST_OFF, ST_ON_DLY, ST_ON, ST_OFF_DLY, ST_NOFF,
        ST_FDLY, ST_FOFF, ST_FHOLD
    } gts_state_t;
endpackage : gts_pkg

// ### rtl/gts_seq_if.sv
/*
 Carrier between the sequencer top and its turn-off phase engine.
 Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ns
interface gts_seq_if;
    import gts_pkg::*;
    logic start;
    logic abort;
    gts_off_mode_t mode;
    logic [7:0] ramp_a;
    logic [7:0] ramp_b;
    logic [7:0] plat_t;
    logic [7:0] plat_lvl;
    logic gate_high;
    gts_phase_t phase;
    logic [7:0] level;
    logic done;
    modport ctl(output start, abort, mode, ramp_a, ramp_b, plat_t, plat_lvl,
        gate_high, input phase, level, done);
    modport seq(input start, abort, mode, ramp_a, ramp_b, plat_t, plat_lvl,
        gate_high, output phase, level, done);
endinterface : gts_seq_if

// ### rtl/gts_offseq.sv
/*
 Turn-off phase engine: hard, two-level (ramp A, plateau, ramp B)
 and soft current-sink discharge.
 Assumes start and abort are one-cycle pulses from the top and that
 gate_high is already synchronised.
*/
`timescale 1ns/1ns
module gts_offseq
    import gts_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control carrier
    gts_seq_if.seq sq
);
    gts_phase_t ph_q, ph_d;
    logic [7:0] c_q, c_d;
    logic [7:0] lvl_q, lvl_d;

    assign sq.phase = ph_q;
    assign sq.level = lvl_q;

    always_comb begin
        ph_d = ph_q;
        c_d = c_q;
        sq.done = 1'b0;
        if (sq.abort) begin
            ph_d = PH_IDLE;
        end else if (sq.start) begin
            case (sq.mode)
                OFF_TWO: begin
                    ph_d = PH_RAMPA;
                    c_d = sq.ramp_a;
                end
                OFF_SOFT: ph_d = PH_SOFT;
                default: ph_d = PH_HARD;
            endcase
        end else begin
            case (ph_q)
                PH_HARD: begin
                    sq.done = 1'b1;
                    ph_d = PH_IDLE;
                end
                PH_RAMPA: begin
                    if (c_q == 8'h00) begin
                        ph_d = PH_PLAT;
                        c_d = sq.plat_t;
                    end else begin
                        c_d = c_q - 8'h01;
                    end
                end
                PH_PLAT: begin
                    if (c_q == 8'h00) begin
                        ph_d = PH_RAMPB;
                        c_d = sq.ramp_b;
                    end else begin
                        c_d = c_q - 8'h01;
                    end
                end
                PH_RAMPB: begin
                    if (c_q != 8'h00) begin
                        c_d = c_q - 8'h01;
                    end else if (!sq.gate_high) begin
                        sq.done = 1'b1;
                        ph_d = PH_IDLE;
                    end
                end
                PH_SOFT: begin
                    if (!sq.gate_high) begin
                        sq.done = 1'b1;
                        ph_d = PH_IDLE;
                    end
                end
                default: ph_d = PH_IDLE;
            endcase
        end
        // Plateau target held through ramp A and the plateau
        lvl_d = (ph_d == PH_RAMPA || ph_d == PH_PLAT) ? sq.plat_lvl : 8'h00;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= PH_IDLE;
            c_q <= 8'h00;
            lvl_q <= 8'h00;
        end else begin
            ph_q <= ph_d;
            c_q <= c_d;
            lvl_q <= lvl_d;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_plat_load;
        ph_q == PH_RAMPA && c_q == 8'h00 && !sq.abort
            |=> ph_q == PH_PLAT && c_q == $past(sq.plat_t);
    endproperty
    a_plat_load: assert property (p_plat_load)
        else $error("plateau not entered after ramp A");

    property p_rampb;
        ph_q == PH_PLAT && c_q == 8'h00 && !sq.abort |=> ph_q == PH_RAMPB;
    endproperty
    a_rampb: assert property (p_rampb)
        else $error("ramp B not entered after plateau");

    property p_plat_lvl;
        ph_q == PH_PLAT |-> lvl_q == $past(sq.plat_lvl);
    endproperty
    a_plat_lvl: assert property (p_plat_lvl)
        else $error("plateau level not driven");

    c_soft_done: cover property (ph_q == PH_SOFT ##1 ph_q == PH_IDLE);
endmodule : gts_offseq

// ### rtl/gts_sequencer.sv
/*
 Output stage sequencer of an isolated gate driver: source/sink output
 control, turn-on, normal and fault turn-off, fault delays, APB slave.
 Assumes pins arrive asynchronously; APB master on pclk.
*/
`timescale 1ns/1ns
`include "gts_consts.svh"
module gts_sequencer
    import gts_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Asynchronous pins and status inputs
    input wire logic switch_cmd,
    input wire logic ready_status_line,
    input wire logic fault_line_low_active_n,
    input wire logic logic_side_supply_ok,
    input wire logic gate_positive_rail_ok,
    input wire logic collector_overvoltage_detect,
    input wire logic gate_side_fault,
    input wire logic gate_above_neg_thresh,
    // Gate output stage
    output logic on_oe,
    output logic off_oe,
    output gts_phase_t off_phase,
    output logic [7:0] off_level,
    output logic [3:0] soft_sink_strength,
    output logic active_shutdown,
    output logic gate_high_flag
);
    localparam logic [16:0] PROP_C = 17'(`GTS_PROP_CYC);
    localparam logic [16:0] DSOUT_C = 17'(`GTS_DSOUT_CYC);

    function automatic logic addr_ok(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= `GTS_A_STAT;
    endfunction : addr_ok

    function automatic logic is_cfg(input logic [7:0] a);
        return a >= `GTS_A_DCFG && a <= `GTS_A_SINK;
    endfunction : is_cfg

    function automatic logic [16:0] ext(input logic [15:0] v);
        return {1'b0, v};
    endfunction : ext

    // Two-stage synchroniser for every pin
    logic [7:0] pin_raw, s1_q, s2_q;
    assign pin_raw = {gate_above_neg_thresh, gate_side_fault,
        collector_overvoltage_detect, gate_positive_rail_ok,
        logic_side_supply_ok, fault_line_low_active_n, ready_status_line,
        switch_cmd};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
        end
    end

    logic cmd_s, rdy_s, flt_s, logic_side_supply_s, gate_positive_rail_s, ds_s, gf_s, gh_s, fault_now;
    assign cmd_s = s2_q[`GTS_I_CMD];
    assign rdy_s = s2_q[`GTS_I_RDY];
    assign flt_s = s2_q[`GTS_I_FLT];
    assign logic_side_supply_s = s2_q[`GTS_I_LOGIC_SIDE_SUPPLY];
    assign gate_positive_rail_s = s2_q[`GTS_I_GATE_POSITIVE_RAIL];
    assign ds_s = s2_q[`GTS_I_DS];
    assign gf_s = s2_q[`GTS_I_GF];
    assign gh_s = s2_q[`GTS_I_GH];
    assign fault_now = !rdy_s || !flt_s || !logic_side_supply_s || !gate_positive_rail_s
        || ds_s || gf_s;

    // Register file
    logic operate_q, operate_d, std_q, std_d;
    logic [1:0] fmet_q, fmet_d;
    logic [15:0] fdly_q, fdly_d;
    logic [7:0] ra_q, ra_d, rb_q, rb_d, plv_q, plv_d, ptm_q, ptm_d;
    logic [3:0] sink_q, sink_d;
    logic [5:0] cause_q, cause_d, cause_clr;
    logic [31:0] prdata_q, prdata_d, rd_val;
    logic acc, wen;
    gts_state_t st_q, st_d;

    assign acc = psel && penable;
    assign pready = 1'b1;
    assign pslverr = acc && (!addr_ok(paddr)
        || (pwrite && operate_q && is_cfg(paddr)));
    assign wen = acc && pwrite && !pslverr;
    assign prdata = prdata_q;

    always_comb begin
        case (paddr)
            `GTS_A_CTRL: rd_val = 32'(operate_q);
            `GTS_A_DCFG: rd_val = 32'(std_q);
            `GTS_A_FMET: rd_val = 32'(fmet_q);
            `GTS_A_FDLY: rd_val = 32'(fdly_q);
            `GTS_A_TSA: rd_val = 32'({rb_q, ra_q});
            `GTS_A_TSB: rd_val = 32'({ptm_q, plv_q});
            `GTS_A_SINK: rd_val = 32'(sink_q);
            `GTS_A_FEV: rd_val = 32'({cause_q, gh_s});
            `GTS_A_STAT: rd_val = 32'(st_q);
            default: rd_val = 32'h0000_0000;
        endcase
        prdata_d = (psel && !penable) ? rd_val : prdata_q;
        operate_d = (wen && paddr == `GTS_A_CTRL) ? pwdata[0] : operate_q;
        std_d = (wen && paddr == `GTS_A_DCFG) ? pwdata[0] : std_q;
        fmet_d = (wen && paddr == `GTS_A_FMET) ? pwdata[1:0] : fmet_q;
        fdly_d = (wen && paddr == `GTS_A_FDLY) ? pwdata[15:0] : fdly_q;
        ra_d = (wen && paddr == `GTS_A_TSA) ? pwdata[7:0] : ra_q;
        rb_d = (wen && paddr == `GTS_A_TSA) ? pwdata[15:8] : rb_q;
        plv_d = (wen && paddr == `GTS_A_TSB) ? pwdata[7:0] : plv_q;
        ptm_d = (wen && paddr == `GTS_A_TSB) ? pwdata[15:8] : ptm_q;
        sink_d = (wen && paddr == `GTS_A_SINK) ? pwdata[3:0] : sink_q;
        cause_clr = (wen && paddr == `GTS_A_FEV) ? pwdata[6:1] : 6'h00;
        // New fault causes win over a clear in the same cycle
        cause_d = (cause_q & ~cause_clr)
            | {gf_s, ds_s, !gate_positive_rail_s, !logic_side_supply_s, !flt_s, !rdy_s};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            operate_q <= 1'b0;
            std_q <= 1'b0;
            fmet_q <= 2'h0;
            fdly_q <= `GTS_RST_FDLY;
            ra_q <= `GTS_RST_RA;
            rb_q <= `GTS_RST_RB;
            plv_q <= `GTS_RST_PLV;
            ptm_q <= `GTS_RST_PTM;
            sink_q <= `GTS_RST_SINK;
            cause_q <= 6'h00;
        end else begin
            prdata_q <= prdata_d;
            operate_q <= operate_d;
            std_q <= std_d;
            fmet_q <= fmet_d;
            fdly_q <= fdly_d;
            ra_q <= ra_d;
            rb_q <= rb_d;
            plv_q <= plv_d;
            ptm_q <= ptm_d;
            sink_q <= sink_d;
            cause_q <= cause_d;
        end
    end

    // Turn-off phase engine
    gts_seq_if sq();
    gts_offseq u_offseq (
        .pclk(pclk),
        .presetn(presetn),
        .sq(sq.seq)
    );

    gts_off_mode_t fmode;
    logic [16:0] cnt_q, cnt_d, cnt_dec, fault_dly;
    logic handling, st_static, st_seq;

    assign fmode = (fmet_q == 2'h3) ? OFF_HARD : gts_off_mode_t'(fmet_q);
    assign cnt_dec = cnt_q - 17'h0_0001;
    assign sq.ramp_a = ra_q;
    assign sq.ramp_b = rb_q;
    assign sq.plat_t = ptm_q;
    assign sq.plat_lvl = plv_q;
    assign sq.gate_high = gh_s;
    assign handling = st_q inside {ST_FDLY, ST_FOFF, ST_FHOLD};
    assign st_static = st_q inside {ST_CFG, ST_OFF, ST_ON_DLY, ST_FHOLD};
    assign st_seq = st_q inside {ST_NOFF, ST_FOFF};

    always_comb begin
        if (ds_s) begin
            fault_dly = DSOUT_C + ext(fdly_q);
        end else if (gf_s || !gate_positive_rail_s) begin
            fault_dly = ext(fdly_q);
        end else begin
            fault_dly = PROP_C + ext(fdly_q);
        end
    end

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sq.start = 1'b0;
        sq.abort = 1'b0;
        sq.mode = OFF_HARD;
        case (st_q)
            ST_CFG: if (operate_q) st_d = ST_OFF;
            ST_OFF: begin
                if (cmd_s) begin
                    st_d = ST_ON_DLY;
                    cnt_d = PROP_C + (std_q ? 17'(ptm_q) : 17'h0_0000);
                end
            end
            ST_ON_DLY: begin
                if (!cmd_s) begin
                    st_d = ST_OFF;
                end else if (cnt_q == 17'h0_0000) begin
                    st_d = ST_ON;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_ON: begin
                if (!cmd_s) begin
                    st_d = ST_OFF_DLY;
                    cnt_d = PROP_C;
                end
            end
            ST_OFF_DLY: begin
                if (cnt_q == 17'h0_0000) begin
                    st_d = ST_NOFF;
                    sq.start = 1'b1;
                    sq.mode = std_q ? OFF_TWO : OFF_HARD;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_NOFF: if (sq.done) st_d = ST_OFF;
            ST_FDLY: begin
                if (cnt_q == 17'h0_0000) begin
                    st_d = ST_FOFF;
                    sq.start = 1'b1;
                    sq.mode = fmode;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_FOFF: if (sq.done) st_d = ST_FHOLD;
            ST_FHOLD: if (!fault_now && !cmd_s) st_d = ST_OFF;
            default: st_d = ST_CFG;
        endcase
        if (!handling && st_q != ST_CFG && fault_now) begin
            st_d = ST_FDLY;
            cnt_d = fault_dly;
            sq.start = 1'b0;
            sq.abort = 1'b1;
        end else if (!operate_q && st_q inside {ST_OFF, ST_ON_DLY, ST_ON,
                ST_OFF_DLY, ST_NOFF, ST_FHOLD}) begin
            st_d = ST_CFG;
            sq.start = 1'b0;
            sq.abort = 1'b1;
        end
    end

    // Registered output stage
    logic on_q, on_d, off_q, off_d, asd_q, asd_d, ghf_q, ghf_d;
    gts_phase_t ph_q, ph_d;
    logic [7:0] lvl_q, lvl_d;
    logic [3:0] soft_q, soft_d;

    always_comb begin
        on_d = st_q inside {ST_ON, ST_OFF_DLY};
        if (st_static) begin
            ph_d = PH_HARD;
        end else if (st_seq) begin
            ph_d = sq.phase;
        end else begin
            ph_d = PH_IDLE;
        end
        off_d = ph_d != PH_IDLE;
        lvl_d = st_seq ? sq.level : 8'h00;
        soft_d = sink_q;
        asd_d = !gate_positive_rail_s;
        ghf_d = gh_s;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_CFG;
            cnt_q <= 17'h0_0000;
            on_q <= 1'b0;
            off_q <= 1'b1;
            ph_q <= PH_HARD;
            lvl_q <= 8'h00;
            soft_q <= 4'h0;
            asd_q <= 1'b1;
            ghf_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            on_q <= on_d;
            off_q <= off_d;
            ph_q <= ph_d;
            lvl_q <= lvl_d;
            soft_q <= soft_d;
            asd_q <= asd_d;
            ghf_q <= ghf_d;
        end
    end

    assign on_oe = on_q;
    assign off_oe = off_q;
    assign off_phase = ph_q;
    assign off_level = lvl_q;
    assign soft_sink_strength = soft_q;
    assign active_shutdown = asd_q;
    assign gate_high_flag = ghf_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_excl;
        !(on_q && off_q);
    endproperty
    a_excl: assert property (p_excl)
        else $error("source and sink enabled together");

    property p_fault_src_off;
        st_q == ST_ON && fault_now |=> st_q == ST_FDLY ##1 !on_q;
    endproperty
    a_fault_src_off: assert property (p_fault_src_off)
        else $error("source not released on fault");

    property p_hold_low;
        st_q == ST_FHOLD && !flt_s |=> off_q && ph_q == PH_HARD;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("sink not low while fault line low");

    property p_asd;
        !gate_positive_rail_s |=> asd_q;
    endproperty
    a_asd: assert property (p_asd)
        else $error("no active shutdown on rail loss");

    property p_fdly_count;
        st_q == ST_FDLY && cnt_q != 17'h0_0000
            |=> st_q == ST_FDLY && cnt_q == $past(cnt_dec);
    endproperty
    a_fdly_count: assert property (p_fdly_count)
        else $error("fault delay not counted");

    property p_gh_flag;
        gh_s ##1 gh_s |=> ghf_q;
    endproperty
    a_gh_flag: assert property (p_gh_flag)
        else $error("gate high flag not set");

    property p_foff_keep;
        st_q == ST_FOFF && !sq.done |=> st_q == ST_FOFF;
    endproperty
    a_foff_keep: assert property (p_foff_keep)
        else $error("fault-off sequence interrupted");

    property p_ton_delay;
        st_q == ST_OFF && cmd_s && !fault_now && operate_q && std_q
            |=> cnt_q == PROP_C + 17'($past(ptm_q));
    endproperty
    a_ton_delay: assert property (p_ton_delay)
        else $error("turn-on delay misses plateau time");

    property p_collector_overvoltage_detect_dly;
        st_q == ST_ON && ds_s |=> cnt_q == DSOUT_C + ext($past(fdly_q));
    endproperty
    a_collector_overvoltage_detect_dly: assert property (p_collector_overvoltage_detect_dly)
        else $error("detect delay wrong");

    property p_lock;
        acc && pwrite && operate_q && is_cfg(paddr)
            |=> $stable({std_q, fmet_q, fdly_q, ra_q, rb_q, plv_q, ptm_q,
                sink_q});
    endproperty
    a_lock: assert property (p_lock)
        else $error("config written while operating");

    c_on: cover property (st_q == ST_ON_DLY ##1 st_q == ST_ON);
    c_tlto: cover property (st_q == ST_NOFF && ph_q == PH_PLAT);
    c_fault: cover property (st_q == ST_FOFF ##1 st_q == ST_FHOLD);
endmodule : gts_sequencer

// ### tb/gts_gate_model.sv
/*
 Behavioural model of the power transistor gate on the far side.
 Assumes the source output charges and the sink output discharges it.
*/
`timescale 1ns/1ns
module gts_gate_model (
    // Clock
    input wire logic pclk,
    // Driver outputs
    input wire logic on_oe,
    input wire logic off_oe,
    // Gate comparator
    output logic gate_above_neg_thresh
);
    logic [3:0] lvl_q = 4'h0;
    // Gate charge follows the drive, one step a cycle
    always @(posedge pclk) begin
        if (on_oe && lvl_q != 4'hF) begin
            lvl_q <= lvl_q + 4'h1;
        end else if (!on_oe && off_oe && lvl_q != 4'h0) begin
            lvl_q <= lvl_q - 4'h1;
        end
    end
    assign gate_above_neg_thresh = lvl_q > 4'h3;
endmodule : gts_gate_model

// ### tb/testbench.sv
/*
 Self-checking bench for the gate output turn-off sequencer.
 Assumes the APB slave answers with zero wait states and a gate model.
*/
`timescale 1ns/1ns
`include "gts_consts.svh"
module testbench;
    import gts_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, gh, on_oe, off_oe, a_sd, ghf;
    logic cmd = 0, rdy = 1, fault_line_low_active = 1, v1 = 1, v2 = 1, ds = 0, gf = 0;
    gts_phase_t ph;
    logic [7:0] lvl;
    logic [3:0] snk;
    int n_errors = 0, tests_run = 0, cyc = 0, n_wait;

    always #4 pclk = ~pclk;

    gts_sequencer dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .switch_cmd(cmd), .ready_status_line(rdy),
        .fault_line_low_active_n(fault_line_low_active), .logic_side_supply_ok(v1),
        .gate_positive_rail_ok(v2), .collector_overvoltage_detect(ds),
        .gate_side_fault(gf), .gate_above_neg_thresh(gh), .on_oe(on_oe),
        .off_oe(off_oe), .off_phase(ph), .off_level(lvl),
        .soft_sink_strength(snk), .active_shutdown(a_sd),
        .gate_high_flag(ghf));
    gts_gate_model gate (.pclk(pclk), .on_oe(on_oe), .off_oe(off_oe),
        .gate_above_neg_thresh(gh));

    task summarize;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    function automatic logic [31:0] pin(input int s);
        case (s)
            0: pin = {31'h0, on_oe};
            1: pin = {31'h0, off_oe};
            2: pin = {31'h0, a_sd};
            3: pin = {31'h0, ghf};
            default: pin = {29'h0, ph};
        endcase
    endfunction : pin

    // Bounded wait until a watched output takes a value
    task wait_for(input int s, input logic [31:0] v);
        n_wait = 0;
        while (pin(s) !== v && n_wait < 400) begin
            @(posedge pclk);
            #1;
            n_wait++;
        end
        chk(pin(s), v);
    endtask : wait_for

    task s_regs;
        apb(0, `GTS_A_FDLY, 0);
        chk(rd, 0);
        apb(0, `GTS_A_TSA, 0);
        chk(rd, 32'h0000_1010);
        apb(0, `GTS_A_TSB, 0);
        chk(rd, 32'h0000_2080);
        apb(0, 8'h40, 0);
        chk(rd, 0);
        chk(er, 1);
        apb(1, `GTS_A_SINK, 3);
        apb(1, `GTS_A_FMET, 2);
        apb(1, `GTS_A_DCFG, 1);
        apb(1, `GTS_A_TSA, 32'h0000_0302);
        apb(1, `GTS_A_TSB, 32'h0000_0440);
        apb(1, `GTS_A_FDLY, 6);
        apb(1, `GTS_A_CTRL, 1);
        apb(1, `GTS_A_SINK, 5);
        chk(er, 1);
        apb(0, `GTS_A_SINK, 0);
        chk(rd, 3);
        chk(snk, 3);
        chk(off_oe, 1);
    endtask : s_regs

    task s_two;
        @(posedge pclk) cmd <= 1;
        wait_for(0, 1);
        // Two sync edges, entry, delay plus plateau time 4, ON, output
        chk(n_wait, `GTS_PROP_CYC + 4 + 5);
        chk(off_oe, 0);
        wait_for(3, 1);
        @(posedge pclk) cmd <= 0;
        wait_for(4, PH_RAMPA);
        chk(n_wait, `GTS_PROP_CYC + 5);
        chk(lvl, 32'h40);
        wait_for(4, PH_PLAT);
        wait_for(4, PH_RAMPB);
        chk(n_wait, 5);
        wait_for(4, PH_HARD);
        chk(ghf, 0);
        chk(on_oe, 0);
    endtask : s_two

    // One fault cause while on; command falls at once and is ignored
    task flt(input int c, input int mn, input gts_phase_t p);
        @(posedge pclk) cmd <= 1;
        wait_for(0, 1);
        wait_for(3, 1);
        @(posedge pclk) cmd <= 0;
        case (c)
            0: rdy <= 0;
            1: fault_line_low_active <= 0;
            2: v1 <= 0;
            3: v2 <= 0;
            4: ds <= 1;
            default: gf <= 1;
        endcase
        wait_for(0, 0);
        wait_for(4, p);
        chk(n_wait >= mn, 1);
        chk(n_wait <= mn + 4, 1);
        wait_for(3, 0);
        chk(off_oe, 1);
        chk(a_sd, c == 3);
        @(posedge pclk) {rdy, fault_line_low_active, v1, v2, ds, gf} <= 6'b111100;
        repeat (12) @(posedge pclk);
    endtask : flt

    task s_modes(input logic [31:0] m, input gts_phase_t p);
        apb(1, `GTS_A_CTRL, 0);
        apb(1, `GTS_A_FMET, m);
        apb(1, `GTS_A_CTRL, 1);
        flt(1, 10, p);
    endtask : s_modes

    initial begin
        repeat (2) @(posedge pclk);
        #1;
        chk(on_oe, 0);
        chk(a_sd, 1);
        repeat (3) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        s_regs();
        s_two();
        flt(1, 10, PH_SOFT);
        flt(0, 10, PH_SOFT);
        flt(2, 10, PH_SOFT);
        flt(3, 5, PH_SOFT);
        flt(4, 30, PH_SOFT);
        flt(5, 5, PH_SOFT);
        s_modes(1, PH_RAMPA);
        s_modes(0, PH_HARD);
        summarize();
    end
endmodule : testbench
